// ===== mcat_pkg.sv
// Contract
// - Word count one to zero raises monitor interrupt
// - Quarter output, bit 30: early monitor
// - Quarter output, bit 31: early end-of-transmission
// - Chain pointer sits just above access word
// - Index realigned, bank extended, bit0 picks word
// - Data address is pointer base plus start
// - External or terminal monitor starts tabling
// - Active table pointer holds count and address
// - Auxiliary table pointer kept alongside active
// - Table address is chain base plus offset
// - Each entry lowers count, raises address, two
// - Empty table reloads active, raises table-full
// - Hardware never alters auxiliary pointer
// - Tabling notified at once or latched
// - First table word carries kind, status, index
// - Second word is access word, external only
// - Function load fetches one word, sends it
// - Function address is output base plus start
// - Terminal count chains when pointer bit 18
// - External interrupt chains when pointer bit 19
// - Part select walks halves, steps on last
// - Quarter mode count is twelve bits wide
// - Bank select extends fifteen bits to 24
// - Step field increments, decrements or holds
package mcat_pkg;
  localparam logic [7:0]  REG_BANK = 8'h00;
  localparam logic [7:0]  REG_CBR  = 8'h04;
  localparam logic [7:0]  REG_ACT  = 8'h08;
  localparam logic [7:0]  REG_AUX  = 8'h0C;
  localparam logic [7:0]  REG_OPTR = 8'h10;
  localparam logic [7:0]  REG_CTRL = 8'h14;
  localparam logic [7:0]  REG_STAT = 8'h18;
  localparam logic [7:0]  REG_FN   = 8'h1C;
  localparam logic [35:0] WORD_RST = 36'h0;
  localparam logic [2:0]  CTRL_RST = 3'h0;
  localparam int          CTRL_QUARTER = 0;
  localparam int          CTRL_MON     = 1;
  localparam int          CTRL_NOTIFY  = 2;
  localparam int          STAT_ACT     = 0;
  localparam int          STAT_BUSY    = 1;
  localparam int          CPW_CHAIN    = 18;
  localparam int          CPW_EICHAIN  = 19;
  localparam int          QC_MON       = 30;
  localparam int          QC_EOT       = 31;
  localparam int          TW_EXT       = 35;
  localparam logic [23:0] TF_OFFSET    = 24'h000096;
  localparam logic [15:0] TAB_STEP     = 16'h0002;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_RD_ACW = 4'h1, ST_RD_CPW = 4'h2, ST_RD_DAT = 4'h3,
    ST_WR_DAT = 4'h4, ST_WR_ACW = 4'h5, ST_CH_ACW = 4'h6, ST_CH_CPW = 4'h7,
    ST_WB_ACW = 4'h8, ST_WB_CPW = 4'h9, ST_TB_W1 = 4'hA, ST_TB_W2 = 4'hB,
    ST_TB_UPD = 4'hC, ST_DONE = 4'hD, ST_FN_ACW = 4'hE, ST_FN_WORD = 4'hF
  } mcat_state_e;
endpackage

// ===== mcat_channel.sv
`timescale 1ns/1ps
`default_nettype none
module mcat_channel (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [35:0] reg_wdata,
  input  wire logic        reg_we,
  input  wire logic        reg_re,
  output logic      [35:0] reg_rdata,
  input  wire logic        idx_valid,
  input  wire logic [35:0] idx_value,
  input  wire logic        idx_output,
  input  wire logic        idx_ext_int,
  input  wire logic [16:0] idx_ext_status,
  output logic             idx_ack,
  output logic             mem_req,
  output logic             mem_we,
  output logic      [23:0] mem_addr,
  output logic      [35:0] mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [35:0] mem_rdata,
  output logic      [17:0] out_char,
  output logic             out_valid,
  output logic      [35:0] fn_word,
  output logic             fn_valid,
  output logic             eot_pulse,
  output logic             mon_int,
  output logic             tab_int,
  output logic             tf_int,
  output logic      [23:0] int_vector
);
  mcat_pkg::mcat_state_e state_r;
  logic        vld_s1_r, vld_s2_r;
  logic [54:0] in_s1_r, in_s2_r;
  logic [35:0] idx_r, acw_r, cpw_r, dat_r, oacw_r;
  logic        dir_r, ext_r;
  logic [16:0] est_r;
  logic [8:0]  bank_r;
  logic [14:0] cbr_r;
  logic [35:0] act_r, aux_r, optr_r;
  logic [2:0]  ctrl_r;
  logic        act_des_r, fn_pend_r;
  logic [23:0] fn_loc_r;
  logic        ack_r, req_r, we_r, ov_r, fv_r, eot_r, mon_r, tab_r, tf_r;
  logic [23:0] addr_r, vec_r;
  logic [35:0] wd_r, rd_r, fnw_r;
  logic [17:0] och_r;

  // Base sits at bit 9 and up, 18-bit relative part added from bit 0
  function automatic logic [23:0] addr_add(input logic [14:0] base, input logic [17:0] rel);
    addr_add = {base, 9'h000} + {6'h00, rel};
  endfunction

  // Access word fields; quarter mode narrows the count to twelve bits
  wire         q_mode   = ctrl_r[mcat_pkg::CTRL_QUARTER];
  wire  [14:0] wcnt     = q_mode ? {3'h0, acw_r[29:18]} : acw_r[32:18];
  wire  [1:0]  hsel     = q_mode ? acw_r[33:32] : {1'b0, acw_r[33]};
  wire  [1:0]  g_fld    = acw_r[35:34];
  wire         last_pt  = q_mode ? (hsel == 2'h3) : hsel[0];
  wire  [14:0] w_nxt    = last_pt ? wcnt - 15'h0001 : wcnt;
  wire  [1:0]  h_nxt    = hsel + 2'h1;
  // Start address moves only after the final part of a word
  wire  [17:0] v_nxt    = !last_pt ? acw_r[17:0] :
                          (g_fld == 2'h0) ? acw_r[17:0] + 18'h00001 :
                          (g_fld == 2'h2) ? acw_r[17:0] - 18'h00001 : acw_r[17:0];
  wire  [35:0] acw_upd  = q_mode ? {g_fld, h_nxt, acw_r[31:30], w_nxt[11:0], v_nxt}
                                 : {g_fld, h_nxt[0], w_nxt, v_nxt};
  wire         term     = last_pt && (wcnt == 15'h0001);
  wire         pre_last = q_mode && dir_r && last_pt && (wcnt == 15'h0002);
  wire         chain_ok = cpw_r[mcat_pkg::CPW_CHAIN];
  wire         mon_en   = ctrl_r[mcat_pkg::CTRL_MON];

  // Part placement: halves low then high, quarters from the top down
  wire  [5:0]  sh       = q_mode ? 6'(({4'h0, 2'h3 - hsel}) * 6'h09) : (hsel[0] ? 6'h12 : 6'h00);
  wire  [35:0] pmask    = q_mode ? 36'h0000001FF : 36'h00003FFFF;
  wire  [35:0] part_w   = (dat_r >> sh) & pmask;
  wire  [35:0] merged   = (dat_r & ~(pmask << sh)) | (({18'h00000, idx_r[35:18]} & pmask) << sh);

  // Addresses for every storage step
  wire  [23:0] acw_addr = {bank_r, idx_r[13:0], 1'b0};
  wire  [23:0] dat_addr = addr_add(cpw_r[35:21], acw_r[17:0]);
  wire  [23:0] chn_addr = addr_add(cbr_r, cpw_r[17:0]);
  wire  [23:0] tab_addr = addr_add(cbr_r, act_r[17:0]);
  wire  [23:0] fnd_addr = addr_add(optr_r[35:21], oacw_r[17:0]);
  wire  [35:0] tab_w1   = {ext_r, ext_r ? est_r : 17'h00000, 4'h0, idx_r[13:0]};
  wire  [15:0] act_cnt  = act_r[33:18];
  wire  [15:0] cnt_nxt  = act_cnt - mcat_pkg::TAB_STEP;
  wire  [17:0] tadr_nxt = act_r[17:0] + {2'h0, mcat_pkg::TAB_STEP};

  wire         mem_st   = (state_r != mcat_pkg::ST_IDLE) && (state_r != mcat_pkg::ST_TB_UPD)
                          && (state_r != mcat_pkg::ST_DONE);
  wire         acc      = req_r && mem_ack;
  wire         accept   = (state_r == mcat_pkg::ST_IDLE) && !fn_pend_r && vld_s2_r && !ack_r;
  wire  [23:0] st_addr  =
    (state_r == mcat_pkg::ST_RD_ACW || state_r == mcat_pkg::ST_WR_ACW ||
     state_r == mcat_pkg::ST_WB_ACW) ? acw_addr :
    (state_r == mcat_pkg::ST_RD_CPW || state_r == mcat_pkg::ST_WB_CPW) ? {acw_addr[23:1], 1'b1} :
    (state_r == mcat_pkg::ST_RD_DAT || state_r == mcat_pkg::ST_WR_DAT) ? dat_addr :
    (state_r == mcat_pkg::ST_CH_ACW) ? chn_addr :
    (state_r == mcat_pkg::ST_CH_CPW) ? chn_addr + 24'h000001 :
    (state_r == mcat_pkg::ST_TB_W1) ? tab_addr :
    (state_r == mcat_pkg::ST_TB_W2) ? tab_addr + 24'h000001 :
    (state_r == mcat_pkg::ST_FN_ACW) ? fn_loc_r : fnd_addr;
  wire         st_we    = (state_r == mcat_pkg::ST_WR_DAT) || (state_r == mcat_pkg::ST_WR_ACW) ||
                          (state_r == mcat_pkg::ST_WB_ACW) || (state_r == mcat_pkg::ST_WB_CPW) ||
                          (state_r == mcat_pkg::ST_TB_W1) || (state_r == mcat_pkg::ST_TB_W2);
  wire  [35:0] st_wdata =
    (state_r == mcat_pkg::ST_WR_DAT) ? merged :
    (state_r == mcat_pkg::ST_WR_ACW) ? acw_upd :
    (state_r == mcat_pkg::ST_WB_CPW) ? cpw_r :
    (state_r == mcat_pkg::ST_TB_W1) ? tab_w1 : acw_r;

  // Register decode
  wire         wr_bank  = reg_we && (reg_addr == mcat_pkg::REG_BANK);
  wire         wr_cbr   = reg_we && (reg_addr == mcat_pkg::REG_CBR);
  wire         wr_act   = reg_we && (reg_addr == mcat_pkg::REG_ACT);
  wire         wr_aux   = reg_we && (reg_addr == mcat_pkg::REG_AUX);
  wire         wr_optr  = reg_we && (reg_addr == mcat_pkg::REG_OPTR);
  wire         wr_ctrl  = reg_we && (reg_addr == mcat_pkg::REG_CTRL);
  wire         wr_stat  = reg_we && (reg_addr == mcat_pkg::REG_STAT);
  wire         wr_fn    = reg_we && (reg_addr == mcat_pkg::REG_FN);
  wire         tab_fin  = (state_r == mcat_pkg::ST_TB_UPD);
  wire         tab_full = tab_fin && (cnt_nxt == 16'h0000);
  wire  [35:0] rd_mux   =
    (reg_addr == mcat_pkg::REG_BANK) ? {27'h0, bank_r} :
    (reg_addr == mcat_pkg::REG_CBR)  ? {21'h0, cbr_r} :
    (reg_addr == mcat_pkg::REG_ACT)  ? act_r :
    (reg_addr == mcat_pkg::REG_AUX)  ? aux_r :
    (reg_addr == mcat_pkg::REG_OPTR) ? optr_r :
    (reg_addr == mcat_pkg::REG_CTRL) ? {33'h0, ctrl_r} :
    (reg_addr == mcat_pkg::REG_STAT) ? {34'h0, state_r != mcat_pkg::ST_IDLE, act_des_r} : 36'h0;

  // Device pins cross two flops before anything looks at them
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      vld_s1_r <= 1'b0;
      vld_s2_r <= 1'b0;
      in_s1_r  <= 55'h0;
      in_s2_r  <= 55'h0;
    end
    else
    begin
      vld_s1_r <= idx_valid;
      vld_s2_r <= vld_s1_r;
      in_s1_r  <= {idx_ext_status, idx_ext_int, idx_output, idx_value};
      in_s2_r  <= in_s1_r;
    end
  end

  // Software registers; table pointer updates by hardware win over writes
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      bank_r    <= 9'h000;
      cbr_r     <= 15'h0000;
      act_r     <= mcat_pkg::WORD_RST;
      aux_r     <= mcat_pkg::WORD_RST;
      optr_r    <= mcat_pkg::WORD_RST;
      ctrl_r    <= mcat_pkg::CTRL_RST;
      act_des_r <= 1'b0;
      fn_pend_r <= 1'b0;
      fn_loc_r  <= 24'h000000;
      rd_r      <= 36'h0;
    end
    else
    begin
      rd_r <= reg_re ? rd_mux : 36'h0;
      if (wr_bank) bank_r <= reg_wdata[8:0];
      if (wr_cbr) cbr_r <= reg_wdata[14:0];
      if (wr_aux) aux_r <= reg_wdata;
      if (wr_optr) optr_r <= reg_wdata;
      if (wr_ctrl) ctrl_r <= reg_wdata[2:0];
      if (tab_full) act_r <= aux_r;
      else if (tab_fin) act_r <= {act_r[35:34], cnt_nxt, tadr_nxt};
      else if (wr_act) act_r <= reg_wdata;
      // Latched activity: a new entry beats a clear in the same cycle
      if (tab_fin && !ctrl_r[mcat_pkg::CTRL_NOTIFY]) act_des_r <= 1'b1;
      else if (wr_stat && reg_wdata[mcat_pkg::STAT_ACT]) act_des_r <= 1'b0;
      if (wr_fn && !fn_pend_r)
      begin
        fn_pend_r <= 1'b1;
        fn_loc_r  <= reg_wdata[23:0];
      end
      else if (state_r == mcat_pkg::ST_FN_ACW) fn_pend_r <= 1'b0;
    end
  end

  // Storage request holds until the answer comes back
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      req_r  <= 1'b0;
      we_r   <= 1'b0;
      addr_r <= 24'h000000;
      wd_r   <= 36'h0;
    end
    else if (mem_st && !req_r)
    begin
      req_r  <= 1'b1;
      we_r   <= st_we;
      addr_r <= st_addr;
      wd_r   <= st_wdata;
    end
    else if (acc) req_r <= 1'b0;
  end

  // Sequencer: fetch, transfer, update, chain and table
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_r <= mcat_pkg::ST_IDLE;
      {idx_r, acw_r, cpw_r, dat_r, oacw_r} <= {5{36'h0}};
      {dir_r, ext_r, est_r} <= 19'h0;
      {ack_r, ov_r, fv_r, eot_r, mon_r, tab_r, tf_r} <= 7'h0;
      och_r <= 18'h0;
      fnw_r <= 36'h0;
      vec_r <= 24'h000000;
    end
    else
    begin
      {ov_r, fv_r, eot_r, mon_r, tab_r, tf_r} <= 6'h0;
      if (!vld_s2_r) ack_r <= 1'b0;
      if (tab_fin)
      begin
        tab_r <= ctrl_r[mcat_pkg::CTRL_NOTIFY];
        tf_r  <= tab_full;
        if (tab_full) vec_r <= mcat_pkg::TF_OFFSET + {15'h0000, bank_r};
      end
      unique case (state_r)
        mcat_pkg::ST_IDLE:
          if (fn_pend_r) state_r <= mcat_pkg::ST_FN_ACW;
          else if (accept)
          begin
            idx_r   <= in_s2_r[35:0];
            dir_r   <= in_s2_r[36];
            ext_r   <= in_s2_r[37];
            est_r   <= in_s2_r[54:38];
            state_r <= mcat_pkg::ST_RD_ACW;
          end
        mcat_pkg::ST_RD_ACW:
          if (acc)
          begin
            acw_r   <= mem_rdata;
            state_r <= mcat_pkg::ST_RD_CPW;
          end
        mcat_pkg::ST_RD_CPW:
          if (acc)
          begin
            cpw_r   <= mem_rdata;
            state_r <= ext_r ? mcat_pkg::ST_TB_W1 :
                       (wcnt == 15'h0000) ? mcat_pkg::ST_DONE : mcat_pkg::ST_RD_DAT;
          end
        mcat_pkg::ST_RD_DAT:
          if (acc)
          begin
            dat_r   <= mem_rdata;
            state_r <= dir_r ? mcat_pkg::ST_WR_ACW : mcat_pkg::ST_WR_DAT;
            if (dir_r)
            begin
              och_r <= 18'((mem_rdata >> sh) & pmask);
              ov_r  <= 1'b1;
              mon_r <= pre_last && acw_r[mcat_pkg::QC_MON];
              eot_r <= pre_last && acw_r[mcat_pkg::QC_EOT];
            end
          end
        mcat_pkg::ST_WR_DAT:
          if (acc) state_r <= mcat_pkg::ST_WR_ACW;
        mcat_pkg::ST_WR_ACW:
          if (acc)
          begin
            mon_r   <= term && !chain_ok && mon_en;
            state_r <= !term ? mcat_pkg::ST_DONE :
                       chain_ok ? mcat_pkg::ST_CH_ACW :
                       mon_en ? mcat_pkg::ST_TB_W1 : mcat_pkg::ST_DONE;
          end
        mcat_pkg::ST_CH_ACW:
          if (acc)
          begin
            acw_r   <= mem_rdata;
            state_r <= mcat_pkg::ST_CH_CPW;
          end
        mcat_pkg::ST_CH_CPW:
          if (acc)
          begin
            cpw_r   <= mem_rdata;
            state_r <= mcat_pkg::ST_WB_ACW;
          end
        mcat_pkg::ST_WB_ACW:
          if (acc) state_r <= mcat_pkg::ST_WB_CPW;
        mcat_pkg::ST_WB_CPW:
          if (acc) state_r <= mcat_pkg::ST_DONE;
        mcat_pkg::ST_TB_W1:
          if (acc) state_r <= ext_r ? mcat_pkg::ST_TB_W2 : mcat_pkg::ST_TB_UPD;
        mcat_pkg::ST_TB_W2:
          if (acc) state_r <= mcat_pkg::ST_TB_UPD;
        mcat_pkg::ST_TB_UPD:
          state_r <= (ext_r && cpw_r[mcat_pkg::CPW_EICHAIN]) ? mcat_pkg::ST_CH_ACW :
                     mcat_pkg::ST_DONE;
        mcat_pkg::ST_DONE:
        begin
          ack_r   <= 1'b1;
          state_r <= mcat_pkg::ST_IDLE;
        end
        mcat_pkg::ST_FN_ACW:
          if (acc)
          begin
            oacw_r  <= mem_rdata;
            state_r <= mcat_pkg::ST_FN_WORD;
          end
        mcat_pkg::ST_FN_WORD:
          if (acc)
          begin
            fnw_r   <= mem_rdata;
            fv_r    <= 1'b1;
            state_r <= mcat_pkg::ST_IDLE;
          end
      endcase
    end
  end

  assign reg_rdata  = rd_r;
  assign idx_ack    = ack_r;
  assign mem_req    = req_r;
  assign mem_we     = we_r;
  assign mem_addr   = addr_r;
  assign mem_wdata  = wd_r;
  assign out_char   = och_r;
  assign out_valid  = ov_r;
  assign fn_word    = fnw_r;
  assign fn_valid   = fv_r;
  assign eot_pulse  = eot_r;
  assign mon_int    = mon_r;
  assign tab_int    = tab_r;
  assign tf_int     = tf_r;
  assign int_vector = vec_r;

  // Checks on the sequencer and the table pointer
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_fn_pulse;
    fv_r ##1 !fv_r;
  endsequence
  AST_ACW_ADDR: assert property (state_r == mcat_pkg::ST_RD_ACW && req_r |->
    addr_r == {bank_r, idx_r[13:0], 1'b0}) else $error("access word address wrong");
  AST_CPW_ADDR: assert property (state_r == mcat_pkg::ST_RD_CPW && req_r |->
    addr_r == {bank_r, idx_r[13:0], 1'b1}) else $error("chain pointer address wrong");
  AST_DAT_ADDR: assert property (state_r == mcat_pkg::ST_RD_DAT && req_r |->
    addr_r == {cpw_r[35:21], 9'h000} + {6'h00, acw_r[17:0]}) else $error("data address wrong");
  AST_TAB_W1: assert property (state_r == mcat_pkg::ST_TB_W1 && req_r |->
    we_r && wd_r[35] == ext_r && wd_r[13:0] == idx_r[13:0]) else $error("table word one wrong");
  AST_PTR_STEP: assert property (tab_fin && act_cnt != 16'h0002 |=>
    act_r[33:18] == $past(act_cnt) - 16'h0002 && act_r[17:0] == $past(act_r[17:0]) + 18'h00002)
    else $error("table pointer step wrong");
  AST_TF: assert property (tab_fin && act_cnt == 16'h0002 |=> tf_r && act_r == $past(aux_r))
    else $error("table full handling wrong");
  AST_AUX: assert property (!wr_aux |=> aux_r == $past(aux_r)) else $error("aux pointer changed");
  AST_FN: assert property (state_r == mcat_pkg::ST_FN_WORD && acc |=> s_fn_pulse)
    else $error("function word not sent once");
  AST_ONE: assert property (state_r != mcat_pkg::ST_IDLE |=> idx_r == $past(idx_r))
    else $error("index changed while busy");
  AST_MON: assert property (state_r == mcat_pkg::ST_WR_ACW && acc && term && !chain_ok && mon_en
    |=> mon_r ##1 state_r == mcat_pkg::ST_TB_W1) else $error("monitor interrupt missing");
endmodule
`default_nettype wire

// ===== mcat_dev.sv
`timescale 1ns/1ps
`default_nettype none
// Remote device side: presents one index, holds it until acknowledged
module mcat_dev (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        start,
  input  wire logic [35:0] s_value,
  input  wire logic        s_output,
  input  wire logic        s_ext,
  input  wire logic [16:0] s_status,
  input  wire logic        idx_ack,
  output logic             idx_valid,
  output logic      [35:0] idx_value,
  output logic             idx_output,
  output logic             idx_ext_int,
  output logic      [16:0] idx_ext_status,
  output logic             busy
);
  // Released value and status lines show an inverted pattern so stale data is never mistaken for valid
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      busy           <= 1'b0;
      idx_valid      <= 1'b0;
      idx_value      <= 36'h0;
      idx_output     <= 1'b0;
      idx_ext_int    <= 1'b0;
      idx_ext_status <= 17'h0;
    end
    else if (!busy && start)
    begin
      busy           <= 1'b1;
      idx_valid      <= 1'b1;
      idx_value      <= {s_value[35:18], 4'h0, s_value[13:0]};
      idx_output     <= s_output;
      idx_ext_int    <= s_ext;
      idx_ext_status <= s_status;
    end
    else if (idx_valid && idx_ack)
    begin
      idx_valid      <= 1'b0;
      idx_value      <= ~idx_value;
      idx_ext_status <= ~idx_ext_status;
    end
    else if (busy && !idx_valid && !idx_ack)
      busy <= 1'b0;
  end
endmodule
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys = 1'b0, sys_rst = 1'b1, reg_we = 1'b0, reg_re = 1'b0, mem_ack = 1'b0;
  logic start = 1'b0, s_output = 1'b0, s_ext = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [35:0] reg_wdata = 36'h0, mem_rdata = 36'h0, s_value = 36'h0;
  logic [16:0] s_status = 17'h0;
  wire logic [35:0] reg_rdata, idx_value, mem_wdata, fn_word;
  wire logic [23:0] mem_addr, int_vector;
  wire logic [17:0] out_char;
  wire logic [16:0] idx_ext_status;
  wire logic idx_valid, idx_output, idx_ext_int, idx_ack, mem_req, mem_we;
  wire logic out_valid, fn_valid, eot_pulse, mon_int, tab_int, tf_int, busy;
  int failures = 0, n_compared = 0, cyc = 0, n_mon = 0, n_tab = 0, n_tf = 0, n_eot = 0, n_fn = 0;
  logic [35:0] mem [logic [23:0]];
  logic [35:0] last_fn = 36'h0;
  logic [17:0] last_char = 18'h0;

  mcat_channel dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .idx_valid(idx_valid), .idx_value(idx_value),
    .idx_output(idx_output), .idx_ext_int(idx_ext_int), .idx_ext_status(idx_ext_status), .idx_ack(idx_ack),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .out_char(out_char), .out_valid(out_valid), .fn_word(fn_word),
    .fn_valid(fn_valid), .eot_pulse(eot_pulse), .mon_int(mon_int), .tab_int(tab_int), .tf_int(tf_int),
    .int_vector(int_vector));
  mcat_dev dev_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .start(start), .s_value(s_value),
    .s_output(s_output), .s_ext(s_ext), .s_status(s_status), .idx_ack(idx_ack), .idx_valid(idx_valid),
    .idx_value(idx_value), .idx_output(idx_output), .idx_ext_int(idx_ext_int),
    .idx_ext_status(idx_ext_status), .busy(busy));

  always #12.5 clk_sys = ~clk_sys;

  // Storage answers one cycle after a request; idle read data keeps toggling
  always @(posedge clk_sys)
  begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req === 1'b1 && !mem_ack)
    begin
      mem_ack <= 1'b1;
      if (mem_we)
        mem[mem_addr] = mem_wdata;
      else
        mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 36'h0;
    end
  end

  // Pulse counters, and a hang guard well above the expected run length
  always @(posedge clk_sys)
  begin
    cyc++;
    if (mon_int === 1'b1) n_mon++;
    if (tab_int === 1'b1) n_tab++;
    if (tf_int === 1'b1) n_tf++;
    if (eot_pulse === 1'b1) n_eot++;
    if (out_valid === 1'b1) last_char = out_char;
    if (fn_valid === 1'b1) n_fn++;
    if (fn_valid === 1'b1) last_fn = fn_word;
    if (cyc == 20000)
    begin
      failures++;
      give_verdict();
    end
  end

  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [35:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk_sys);
    reg_we <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [35:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk_sys);
    reg_re <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // One index presented and served to completion
  task automatic serve(input logic [35:0] v, input logic o, input logic e, input logic [16:0] st);
    int i;
    @(posedge clk_sys);
    s_value <= v;
    s_output <= o;
    s_ext <= e;
    s_status <= st;
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    #1;
    for (i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clk_sys);
    repeat (3) @(posedge clk_sys);
  endtask

  function automatic logic [23:0] aw(input logic [13:0] x);
    return {9'h005, x, 1'b0};
  endfunction

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic t_regs;
    logic [35:0] d;
    for (int a = 0; a < 28; a += 4)
    begin
      reg_rd(8'(a), d);
      chk(d, 36'h0);
    end
    reg_rd(8'h40, d);
    chk(d, 36'h0);
    reg_wr(mcat_pkg::REG_BANK, 36'h005);
    reg_wr(mcat_pkg::REG_CBR, 36'h003);
    reg_wr(mcat_pkg::REG_OPTR, {15'h0002, 21'h0});
    reg_rd(mcat_pkg::REG_BANK, d);
    chk(d, 36'h005);
    $display("t_regs done");
  endtask

  // Half-word input: both halves, then step down and count
  task automatic t_half;
    mem[aw(14'h0123)] = {2'b10, 1'b0, 15'h0002, 18'h00010};
    mem[aw(14'h0123) + 24'h1] = {15'h0001, 21'h0};
    mem[24'h000210] = 36'h0;
    serve({18'h2AAAA, 18'h00123}, 1'b0, 1'b0, 17'h0);
    chk(mem[24'h000210], {18'h0, 18'h2AAAA});
    chk(mem[aw(14'h0123)], {2'b10, 1'b1, 15'h0002, 18'h00010});
    serve({18'h15555, 18'h00123}, 1'b0, 1'b0, 17'h0);
    chk(mem[24'h000210], {18'h15555, 18'h2AAAA});
    chk(mem[aw(14'h0123)], {2'b10, 1'b0, 15'h0001, 18'h0000F});
    $display("t_half done");
  endtask

  task automatic t_chain;
    mem[aw(14'h0123)] = {2'b00, 1'b1, 15'h0001, 18'h00010};
    mem[aw(14'h0123) + 24'h1] = {15'h0001, 3'b001, 18'h00040};
    mem[24'h000640] = 36'h012345678;
    mem[24'h000641] = 36'h300000000;
    serve({18'h3C3C3, 18'h00123}, 1'b0, 1'b0, 17'h0);
    chk(mem[aw(14'h0123)], 36'h012345678);
    chk(mem[aw(14'h0123) + 24'h1], 36'h300000000);
    $display("t_chain done");
  endtask

  // Monitor terminal count empties the table
  task automatic t_mon;
    int m0, t0, f0;
    logic [35:0] d;
    m0 = n_mon;
    t0 = n_tab;
    f0 = n_tf;
    reg_wr(mcat_pkg::REG_CTRL, 36'h6);
    reg_wr(mcat_pkg::REG_ACT, {2'b00, 16'h0002, 18'h00020});
    reg_wr(mcat_pkg::REG_AUX, {2'b00, 16'h0010, 18'h00100});
    mem[aw(14'h0040)] = {2'b01, 1'b1, 15'h0001, 18'h00030};
    mem[aw(14'h0040) + 24'h1] = {15'h0001, 21'h0};
    mem[24'h000621] = 36'h0000005A5;
    serve({18'h00011, 18'h00040}, 1'b0, 1'b0, 17'h0);
    chk(36'(n_mon - m0), 36'h1);
    chk(mem[aw(14'h0040)], {2'b01, 1'b0, 15'h0000, 18'h00030});
    chk(36'(n_tab - t0), 36'h1);
    chk(mem[24'h000620], {1'b0, 17'h0, 4'h0, 14'h0040});
    chk(mem[24'h000621], 36'h0000005A5);
    chk(36'(n_tf - f0), 36'h1);
    chk({12'h0, int_vector}, 36'h00000009B);
    reg_rd(mcat_pkg::REG_ACT, d);
    chk(d, {2'b00, 16'h0010, 18'h00100});
    reg_rd(mcat_pkg::REG_AUX, d);
    chk(d, {2'b00, 16'h0010, 18'h00100});
    $display("t_mon done");
  endtask

  // External interrupt with chaining, latched notification
  task automatic t_ext;
    int t0;
    logic [35:0] d, old;
    t0 = n_tab;
    reg_wr(mcat_pkg::REG_CTRL, 36'h2);
    old = mem[aw(14'h0040)];
    mem[aw(14'h0040) + 24'h1] = {15'h0001, 3'b010, 18'h00050};
    mem[24'h000650] = 36'h0ABCDEF01;
    mem[24'h000651] = 36'h000000077;
    serve({18'h0, 18'h00040}, 1'b0, 1'b1, 17'h1ABCD);
    chk(mem[24'h000700], {1'b1, 17'h1ABCD, 4'h0, 14'h0040});
    chk(mem[24'h000701], old);
    chk(mem[aw(14'h0040)], 36'h0ABCDEF01);
    chk(mem[aw(14'h0040) + 24'h1], 36'h000000077);
    reg_rd(mcat_pkg::REG_ACT, d);
    chk(d, {2'b00, 16'h000E, 18'h00102});
    chk(36'(n_tab - t0), 36'h0);
    reg_rd(mcat_pkg::REG_STAT, d);
    chk({35'h0, d[0]}, 36'h1);
    reg_wr(mcat_pkg::REG_STAT, 36'h1);
    reg_rd(mcat_pkg::REG_STAT, d);
    chk({35'h0, d[0]}, 36'h0);
    $display("t_ext done");
  endtask

  // Quarter output, both control bits set, count two to one
  task automatic t_quart;
    int m0, e0;
    m0 = n_mon;
    e0 = n_eot;
    reg_wr(mcat_pkg::REG_CTRL, 36'h1);
    mem[aw(14'h00C0)] = {2'b00, 2'b11, 2'b11, 12'h002, 18'h00010};
    mem[aw(14'h00C0) + 24'h1] = {15'h0001, 21'h0};
    mem[24'h000210] = {27'h0, 9'h1A5};
    serve({18'h0, 18'h000C0}, 1'b1, 1'b0, 17'h0);
    chk({27'h0, last_char[8:0]}, 36'h0000001A5);
    chk(36'(n_mon - m0), 36'h1);
    chk(36'(n_eot - e0), 36'h1);
    chk(mem[aw(14'h00C0)], {2'b00, 2'b00, 2'b11, 12'h001, 18'h00011});
    $display("t_quart done");
  endtask

  task automatic t_fn;
    mem[24'h000900] = {2'b00, 1'b0, 15'h0001, 18'h00020};
    mem[24'h000420] = 36'h987654321;
    reg_wr(mcat_pkg::REG_FN, 36'h000000900);
    repeat (40) @(posedge clk_sys);
    chk(last_fn, 36'h987654321);
    chk(36'(n_fn), 36'h1);
    $display("t_fn done");
  endtask

  initial
  begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs();
    t_half();
    t_chain();
    t_mon();
    t_ext();
    t_quart();
    t_fn();
    give_verdict();
  end
endmodule
`default_nettype wire
